// ---- hdl/cdrs_pkg.sv ----
// constants, register map and state type for the clock divider and reset sequencer
// Function
// RL1: internal clock drives auto-reload timer; divide-by-12 and divide-by-13 copies derived.
// RL2: instructions take two, four or five machine cycles.
// RL3: divider control register at data address dch, write-only, bits 7-4 unused.
// RL4: select field 00 divides by 1, 01 by 2, 10 and 11 by 4.
// RL5: low-power bit clears on reset; software sets it for lowest power.
// RL6: software always writes zero to the keep-low bit.
// RL7: software keeps a RAM shadow, written first, if writing from interrupt handlers.
// RL8: reset sources are reset pin low, power-on detection and watchdog timeout.
// RL9: reset pin honoured in run, wait and stop; held in reset while low.
// RL10: internal reset extends external reset by a delay, so short pulses suffice.
// RL11: reset in run or wait halts execution, pulls up I/O, restarts oscillator.
// RL12: reset in stop starts oscillator, pulls up I/O, initialises after delay.
// RL13: on-chip counter holds internal reset 2048 internal cycles after release.
// RL14: delay option selects 2048 cycles when low, 32768 when high.
// RL15: watchdog end of count asserts internal reset and reinitialises watchdog counter.
// RL16: watchdog reset takes the same restart path including full delay.
// RL17: reset input has an internal pull-up.
// RL18: initialisation clears return stack and loads program counter from reset vector.
// RL19: after reset the core runs in non-maskable context until a return.
// RL20: non-maskable carry and zero flag pair used until context changes.
// RL21: software ends initialisation with a return-from-interrupt.
// RL22: after that return, pending interrupt is serviced at once, else execution continues.
// RL23: oscillator option selects crystal/resonator/external clock or RC mode.
// RL24: reset release and ratio changes synchronised to internal clock, no runt pulses.
package cdrs_pkg;

  // register addresses on the data bus
  localparam logic [7:0] ADDR_DIV_CTRL     = 8'hdc;
  localparam logic [7:0] ADDR_STATUS       = 8'hde;

  // divider control field layout and reset value
  localparam int         DIV_SEL_LSB       = 0;
  localparam int         KEEP_LOW_BIT      = 2;
  localparam int         LOW_POWER_BIT     = 3;
  localparam logic [3:0] DIV_CTRL_RESET    = 4'h0;

  // status field layout
  localparam int         ST_CAUSE_PIN      = 0;
  localparam int         ST_CAUSE_POR      = 1;
  localparam int         ST_CAUSE_WDG      = 2;
  localparam int         ST_NMI_CTX        = 3;
  localparam int         ST_RATIO_LSB      = 4;
  localparam int         ST_DELAY_LONG     = 6;
  localparam int         ST_RUNNING        = 7;
  localparam logic [2:0] CAUSE_RESET       = 3'h2;

  // fixed dividers of the internal clock
  localparam int         PERIPH_RATIO      = 12;
  localparam int         MACHINE_RATIO     = 13;

  // start-up delay in internal clock cycles
  localparam int         STARTUP_SHORT     = 2048;
  localparam int         STARTUP_LONG      = 32768;

  // initialisation values handed to the core
  localparam logic [11:0] RESET_VECTOR     = 12'hffe;
  localparam logic [1:0]  FLAGS_NORMAL     = 2'h0;
  localparam logic [1:0]  FLAGS_NMI        = 2'h2;

  // machine cycles per instruction length code
  localparam logic [2:0] MC_LEN_SHORT      = 3'h2;
  localparam logic [2:0] MC_LEN_MID        = 3'h4;
  localparam logic [2:0] MC_LEN_LONG       = 3'h5;

  // reset sequencer states
  typedef enum logic [1:0] {
    SEQ_HOLD  = 2'b00,
    SEQ_DELAY = 2'b01,
    SEQ_INIT  = 2'b10,
    SEQ_RUN   = 2'b11
  } cdrs_seq_type;

endpackage

// ---- hdl/cdrs_tick_div.sv ----
// fixed-ratio divider turning an input tick stream into a slower tick stream
`timescale 1ns/1ns
`default_nettype none
module cdrs_tick_div #(
  parameter int RATIO = 12
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // tick in and out
  input  wire logic tick_i,
  output logic      tick_o
);

  localparam int CW = $clog2(RATIO);
  localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

  logic [CW-1:0] cnt;

  // count input ticks, wrap on the last one
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= '0;
    end
    else if (tick_i)
    begin
      cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
    end
  end

  // one output tick per RATIO input ticks, always a full period wide apart
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= tick_i && (cnt == LAST);
    end
  end

endmodule // cdrs_tick_div
`default_nettype wire

// ---- hdl/cdrs_clock_reset.sv ----
// clock divider, reset merging and start-up sequencer of the microcontroller
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module cdrs_clock_reset #(
  parameter int STARTUP_SHORT_CYCLES = cdrs_pkg::STARTUP_SHORT,
  parameter int STARTUP_LONG_CYCLES  = cdrs_pkg::STARTUP_LONG
) (
  // clock (oscillator rate) and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [7:0]       rdata_o,
  // reset sources
  input  wire logic        reset_pin_n_i,
  input  wire logic        por_i,
  input  wire logic        wdg_timeout_i,
  output logic             reset_pin_pullup_o,
  // option bits
  input  wire logic        delay_option_i,
  input  wire logic        oscillator_type_option_i,
  // power mode and core handshake
  input  wire logic        stop_mode_i,
  input  wire logic        instr_start_i,
  input  wire logic [1:0]  instr_len_i,
  input  wire logic        return_from_interrupt_i,
  input  wire logic        irq_pending_i,
  // derived clock ticks
  output logic             int_tick_o,
  output logic             periph_tick_o,
  output logic             machine_tick_o,
  output logic             instr_done_o,
  // reset and initialisation outputs
  output logic             core_reset_o,
  output logic             io_pullup_o,
  output logic             wdg_reinit_o,
  output logic             osc_restart_o,
  output logic             osc_enable_o,
  output logic             osc_rc_mode_o,
  output logic             low_power_o,
  output logic             stack_clear_o,
  output logic             pc_load_o,
  output logic [11:0]      pc_vector_o,
  output logic             nmi_context_o,
  output logic [1:0]       flag_pair_o,
  output logic             irq_take_o
);

  localparam logic [15:0] SHORT_LAST = 16'(STARTUP_SHORT_CYCLES - 1);
  localparam logic [15:0] LONG_LAST  = 16'(STARTUP_LONG_CYCLES - 1);

  cdrs_pkg::cdrs_seq_type state;
  cdrs_pkg::cdrs_seq_type next_state;

  logic [3:0]  div_ctrl;
  logic [1:0]  ratio_last;
  logic [1:0]  next_ratio_last;
  logic [1:0]  pre_cnt;
  logic [2:0]  pin_sync;
  logic [2:0]  por_sync;
  logic        pin_low;
  logic        por_act;
  logic        hold_req;
  logic [15:0] dly_cnt;
  logic [15:0] dly_last;
  logic        delay_long;
  logic [2:0]  cause;
  logic [2:0]  mc_left;
  logic        div_wr;
  logic        stat_wr;

  assign div_wr  = wr_i && (addr_i == cdrs_pkg::ADDR_DIV_CTRL);
  assign stat_wr = wr_i && (addr_i == cdrs_pkg::ADDR_STATUS);

  // divider control: only the low nibble is stored, nothing reads it back;
  // every internal reset clears it, so a restart always comes up at /1 with low power off
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      div_ctrl <= cdrs_pkg::DIV_CTRL_RESET; // RL5
    end
    else if (state == cdrs_pkg::SEQ_HOLD)
    begin
      div_ctrl <= cdrs_pkg::DIV_CTRL_RESET; // RL5
    end
    else if (div_wr)
    begin
      div_ctrl <= wdata_i[3:0]; // RL3
    end
  end

  // select code to divisor minus one: 0, 1, 3, 3
  always_comb
  begin
    unique case (div_ctrl[cdrs_pkg::DIV_SEL_LSB +: 2])
      2'b00:   next_ratio_last = 2'd0; // RL4
      2'b01:   next_ratio_last = 2'd1; // RL4
      default: next_ratio_last = 2'd3; // RL4
    endcase
  end

  // predivider; a new ratio is taken only at a tick so no internal cycle is cut short
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pre_cnt    <= 2'd0;
      ratio_last <= 2'd0;
      int_tick_o <= 1'b0;
    end
    else
    begin
      if (pre_cnt >= ratio_last)
      begin
        pre_cnt    <= 2'd0;
        ratio_last <= next_ratio_last; // RL24
      end
      else
      begin
        pre_cnt <= pre_cnt + 2'd1;
      end
      int_tick_o <= (pre_cnt >= ratio_last); // RL1
    end
  end

  // timer, converter and watchdog tick
  cdrs_tick_div #(
    .RATIO (cdrs_pkg::PERIPH_RATIO)
  ) u_periph_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_i  (int_tick_o),
    .tick_o  (periph_tick_o)
  ); // RL1

  // core machine cycle tick
  cdrs_tick_div #(
    .RATIO (cdrs_pkg::MACHINE_RATIO)
  ) u_machine_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_i  (int_tick_o),
    .tick_o  (machine_tick_o)
  ); // RL1

  // pin level synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_sync <= 3'h7;
      por_sync <= 3'h0;
      pin_low  <= 1'b0;
      por_act  <= 1'b0;
    end
    else
    begin
      pin_sync <= {pin_sync[1:0], reset_pin_n_i};
      por_sync <= {por_sync[1:0], por_i};
      if (pin_sync[1] == pin_sync[2])
      begin
        pin_low <= !pin_sync[2]; // RL9
      end
      if (por_sync[1] == por_sync[2])
      begin
        por_act <= por_sync[2];
      end
    end
  end

  // level sources keep the sequencer held; the watchdog pulse forces one hold cycle
  assign hold_req = pin_low || por_act; // RL8

  // option bits are latched while held in reset, so they cannot change mid-run
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      delay_long    <= 1'b0;
      osc_rc_mode_o <= 1'b0;
    end
    else if (state == cdrs_pkg::SEQ_HOLD)
    begin
      delay_long    <= delay_option_i; // RL14
      osc_rc_mode_o <= oscillator_type_option_i; // RL23
    end
  end

  assign dly_last = delay_long ? LONG_LAST : SHORT_LAST; // RL14

  // sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      cdrs_pkg::SEQ_HOLD:
      begin
        if (!hold_req && !wdg_timeout_i)
        begin
          next_state = cdrs_pkg::SEQ_DELAY; // RL10
        end
      end
      cdrs_pkg::SEQ_DELAY:
      begin
        if (hold_req || wdg_timeout_i)
        begin
          next_state = cdrs_pkg::SEQ_HOLD; // RL9
        end
        else if (int_tick_o && (dly_cnt == dly_last))
        begin
          next_state = cdrs_pkg::SEQ_INIT; // RL13 RL24
        end
      end
      cdrs_pkg::SEQ_INIT:
      begin
        if (hold_req || wdg_timeout_i)
        begin
          next_state = cdrs_pkg::SEQ_HOLD;
        end
        else
        begin
          next_state = cdrs_pkg::SEQ_RUN;
        end
      end
      cdrs_pkg::SEQ_RUN:
      begin
        if (hold_req || wdg_timeout_i)
        begin
          next_state = cdrs_pkg::SEQ_HOLD; // RL15 RL16
        end
      end
    endcase
  end

  // sequencer state; power-up enters the held state
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= cdrs_pkg::SEQ_HOLD;
    end
    else
    begin
      state <= next_state;
    end
  end

  // start-up counter runs on internal clock ticks, restarts at every hold
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      dly_cnt <= 16'h0000;
    end
    else if (state != cdrs_pkg::SEQ_DELAY)
    begin
      dly_cnt <= 16'h0000;
    end
    else if (int_tick_o)
    begin
      dly_cnt <= dly_cnt + 16'h0001; // RL13
    end
  end

  // reset side effects; stop mode is overridden while reset is in progress
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      core_reset_o  <= 1'b1;
      io_pullup_o   <= 1'b1;
      wdg_reinit_o  <= 1'b1;
      osc_restart_o <= 1'b0;
      osc_enable_o  <= 1'b1;
    end
    else
    begin
      core_reset_o  <= (next_state != cdrs_pkg::SEQ_RUN); // RL11
      io_pullup_o   <= (next_state != cdrs_pkg::SEQ_RUN); // RL11 RL12
      wdg_reinit_o  <= (next_state == cdrs_pkg::SEQ_HOLD); // RL15
      osc_restart_o <= (state != cdrs_pkg::SEQ_HOLD) && (next_state == cdrs_pkg::SEQ_HOLD); // RL11
      osc_enable_o  <= !(stop_mode_i && (next_state == cdrs_pkg::SEQ_RUN)); // RL12
    end
  end

  // initialisation pulses toward the core
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      stack_clear_o <= 1'b0;
      pc_load_o     <= 1'b0;
      pc_vector_o   <= cdrs_pkg::RESET_VECTOR;
    end
    else
    begin
      stack_clear_o <= (next_state == cdrs_pkg::SEQ_INIT); // RL18
      pc_load_o     <= (next_state == cdrs_pkg::SEQ_INIT); // RL18
      pc_vector_o   <= cdrs_pkg::RESET_VECTOR; // RL18
    end
  end

  // non-maskable context from initialisation until the first return
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      nmi_context_o <= 1'b1;
      flag_pair_o   <= cdrs_pkg::FLAGS_NMI;
      irq_take_o    <= 1'b0;
    end
    else if (next_state != cdrs_pkg::SEQ_RUN)
    begin
      nmi_context_o <= 1'b1; // RL19
      flag_pair_o   <= cdrs_pkg::FLAGS_NMI; // RL20
      irq_take_o    <= 1'b0;
    end
    else if (return_from_interrupt_i && nmi_context_o)
    begin
      nmi_context_o <= 1'b0;
      flag_pair_o   <= cdrs_pkg::FLAGS_NORMAL; // RL20
      irq_take_o    <= irq_pending_i; // RL22
    end
    else
    begin
      irq_take_o <= 1'b0;
    end
  end

  // instruction length in machine cycles; a new start reloads the count
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mc_left      <= 3'h0;
      instr_done_o <= 1'b0;
    end
    else if (state != cdrs_pkg::SEQ_RUN)
    begin
      mc_left      <= 3'h0;
      instr_done_o <= 1'b0;
    end
    else
    begin
      instr_done_o <= machine_tick_o && (mc_left == 3'h1); // RL2
      if (instr_start_i)
      begin
        unique case (instr_len_i)
          2'b00:   mc_left <= cdrs_pkg::MC_LEN_SHORT; // RL2
          2'b01:   mc_left <= cdrs_pkg::MC_LEN_MID; // RL2
          default: mc_left <= cdrs_pkg::MC_LEN_LONG; // RL2
        endcase
      end
      else if (machine_tick_o && (mc_left != 3'h0))
      begin
        mc_left <= mc_left - 3'h1;
      end
    end
  end

  // sticky reset causes; a new cause wins over a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cause <= cdrs_pkg::CAUSE_RESET;
    end
    else
    begin
      cause <= (cause & ~(stat_wr ? wdata_i[2:0] : 3'h0))
             | {wdg_timeout_i, por_act, pin_low}; // RL8
    end
  end

  // read port; the divider register is write-only and reads as zero
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (rd_i && (addr_i == cdrs_pkg::ADDR_STATUS))
    begin
      rdata_o <= {state == cdrs_pkg::SEQ_RUN, delay_long, ratio_last, nmi_context_o, cause};
    end
    else
    begin
      rdata_o <= 8'h00; // RL3
    end
  end

  // lowest-power setting follows the software bit directly
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      low_power_o        <= 1'b0;
      reset_pin_pullup_o <= 1'b1;
    end
    else
    begin
      low_power_o        <= div_ctrl[cdrs_pkg::LOW_POWER_BIT]; // RL5
      reset_pin_pullup_o <= 1'b1; // RL17
    end
  end

endmodule // cdrs_clock_reset
`default_nettype wire

// ---- testbench/cdrs_sva.sv ----
// assertion checker for the clock divider and reset sequencer ports
`timescale 1ns/1ns
`default_nettype none
module cdrs_sva (
  // clock, reset and register port
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  // reset sources and core handshake
  input wire logic        reset_pin_n_i,
  input wire logic        wdg_timeout_i,
  input wire logic        return_from_interrupt_i,
  input wire logic        irq_pending_i,
  // watched outputs
  input wire logic        reset_pin_pullup_o,
  input wire logic        int_tick_o,
  input wire logic        periph_tick_o,
  input wire logic        machine_tick_o,
  input wire logic        core_reset_o,
  input wire logic        io_pullup_o,
  input wire logic        wdg_reinit_o,
  input wire logic        low_power_o,
  input wire logic        stack_clear_o,
  input wire logic        pc_load_o,
  input wire logic [11:0] pc_vector_o,
  input wire logic        nmi_context_o,
  input wire logic [1:0]  flag_pair_o,
  input wire logic        irq_take_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [4:0] per_n;
  logic [4:0] mac_n;
  logic       per_ok;
  logic       mac_ok;

  // internal ticks per peripheral tick; windows dropped in reset since dividers may restart
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || core_reset_o)
      per_ok <= 1'b0;
    else if (periph_tick_o)
      per_ok <= 1'b1;
    per_n <= periph_tick_o ? {4'h0, int_tick_o} : per_n + {4'h0, int_tick_o};
  end

  // internal ticks per machine tick
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || core_reset_o)
      mac_ok <= 1'b0;
    else if (machine_tick_o)
      mac_ok <= 1'b1;
    mac_n <= machine_tick_o ? {4'h0, int_tick_o} : mac_n + {4'h0, int_tick_o};
  end

  sequence s_pin_low;
    (!reset_pin_n_i) [*6];
  endsequence
  sequence s_rfi_nmi;
    return_from_interrupt_i && nmi_context_o && !core_reset_o;
  endsequence

  a_periph_twelve: assert property (periph_tick_o && per_ok |-> per_n == 5'h0c)
    else $error("peripheral tick spacing wrong");
  a_machine_thirteen: assert property (machine_tick_o && mac_ok |-> mac_n == 5'h0d)
    else $error("machine tick spacing wrong");
  a_pin_holds_reset: assert property (s_pin_low |-> core_reset_o)
    else $error("core ran with reset pin low");
  a_wdg_forces_hold: assert property (wdg_timeout_i |-> ##[1:2] (core_reset_o && wdg_reinit_o))
    else $error("watchdog timeout did not reset");
  a_init_loads_vector: assert property (pc_load_o |-> stack_clear_o && core_reset_o
    && pc_vector_o == cdrs_pkg::RESET_VECTOR ##[1:2] !core_reset_o)
    else $error("initialisation step wrong");
  a_rfi_leaves_nmi: assert property (s_rfi_nmi |=> !nmi_context_o && flag_pair_o == cdrs_pkg::FLAGS_NORMAL
    && irq_take_o == $past(irq_pending_i))
    else $error("return did not leave nmi context");
  a_flags_follow_ctx: assert property (flag_pair_o == (nmi_context_o ? cdrs_pkg::FLAGS_NMI
    : cdrs_pkg::FLAGS_NORMAL))
    else $error("flag pair does not match context");
  a_pullups_held: assert property (reset_pin_pullup_o && io_pullup_o == core_reset_o)
    else $error("pull-up outputs wrong");
  a_low_power_write: assert property (wr_i && addr_i == cdrs_pkg::ADDR_DIV_CTRL
    |-> ##2 low_power_o == $past(wdata_i[3], 2))
    else $error("low power bit not taken");
  a_reads_quiet: assert property ((!rd_i || addr_i == cdrs_pkg::ADDR_DIV_CTRL) |=> rdata_o == 8'h00)
    else $error("read data not zero");
endmodule // cdrs_sva
bind cdrs_clock_reset cdrs_sva cdrs_sva_i (.*);
`default_nettype wire

// ---- testbench/cdrs_pin_src.sv ----
// board reset source pulling the reset pin low for a set number of cycles
`timescale 1ns/1ns
`default_nettype none
module cdrs_pin_src (
  // clock and command
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] len_i,
  // reset pin
  output logic            pin_n_o
);
  logic [7:0] cnt = 8'h00;

  // low time counter; a short count models a brief glitch, a long one a slow supervisor
  always_ff @(posedge clk_i)
  begin
    if (go_i)
      cnt <= len_i;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end

  // released pin floats back high through the pull-up
  assign pin_n_o = (cnt == 8'h00);
endmodule // cdrs_pin_src
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking testbench of the clock divider and reset sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int NS = 8;
  localparam int NL = 16;
  logic        clk_i, rst_n_i, wr, rd, por, wdg, dopt, otyp, stop, istart, rfi, irqp, go, pin_n;
  logic [7:0]  addr, wdata, rdata, plen, v, shadow;
  logic [1:0]  ilen, flg;
  logic [11:0] pcv;
  logic        intk, pert, mact, idone, crst, iopu, wre, orst, oen, orc, lowp, sclr, pcld, ppu, nmi, itk;
  int          bad_count, n_checks, cyc, loads, rsts, n, t, w;

  cdrs_clock_reset #(.STARTUP_SHORT_CYCLES(NS), .STARTUP_LONG_CYCLES(NL)) cdrs_clock_reset_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .reset_pin_n_i(pin_n), .por_i(por), .wdg_timeout_i(wdg), .reset_pin_pullup_o(ppu),
    .delay_option_i(dopt), .oscillator_type_option_i(otyp), .stop_mode_i(stop), .instr_start_i(istart),
    .instr_len_i(ilen), .return_from_interrupt_i(rfi), .irq_pending_i(irqp), .int_tick_o(intk),
    .periph_tick_o(pert), .machine_tick_o(mact), .instr_done_o(idone), .core_reset_o(crst),
    .io_pullup_o(iopu), .wdg_reinit_o(wre), .osc_restart_o(orst), .osc_enable_o(oen), .osc_rc_mode_o(orc),
    .low_power_o(lowp), .stack_clear_o(sclr), .pc_load_o(pcld), .pc_vector_o(pcv), .nmi_context_o(nmi),
    .flag_pair_o(flg), .irq_take_o(itk));
  cdrs_pin_src cdrs_pin_src_i (.clk_i(clk_i), .go_i(go), .len_i(plen), .pin_n_o(pin_n));

  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk_i);
    addr <= a; rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 r = rdata;
  endtask
  // waits for a reset to be seen and then lifted, counting cycles
  task automatic wait_run(output int k);
    logic seen;
    k = 0;
    seen = 1'b0;
    while ((!seen || crst !== 1'b0) && k < 600)
    begin
      @(posedge clk_i);
      #1 k++;
      seen |= (crst === 1'b1);
    end
    chk(k < 600, 1);
  endtask
  task automatic pulse_pin(input logic [7:0] len);
    @(posedge clk_i);
    plen <= len; go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // timeout and counts of initialisation and restart pulses
  always @(posedge clk_i)
  begin
    cyc++;
    loads += (pcld === 1'b1);
    rsts += (orst === 1'b1);
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test;
    end
  end

  // main sequence
  initial
  begin
    {rst_n_i, wr, rd, por, wdg, dopt, otyp, stop, istart, rfi, irqp, go} = '0;
    {addr, wdata, plen, ilen} = '0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wait_run(n);
    chk(lowp, 0);
    chk(loads, 1);
    rreg(8'hde, v);
    chk(v, 8'h8a);
    rreg(8'hdc, v);
    chk(v, 8'h00);
    wreg(8'h55, 8'hff);
    rreg(8'h55, v);
    chk({v, 3'h0, lowp}, 0);
    // every select code, upper bits set to show they are ignored, bit 2 kept low
    for (int k = 0; k < 4; k++)
    begin
      shadow = {4'hf, 2'b10, k[1:0]};
      wreg(8'hdc, shadow);
      repeat (8) @(posedge clk_i);
      t = 0;
      repeat (16) @(posedge clk_i) #1 t += intk;
      chk(t, (k == 0) ? 16 : (k == 1) ? 8 : 4);
      rreg(8'hde, v);
      chk(v[5:4], (k == 0) ? 0 : (k == 1) ? 1 : 3);
    end
    chk(lowp, 1);
    shadow = 8'h08;
    wreg(8'hdc, shadow);
    // each instruction length starts just after a machine tick
    for (int k = 0; k < 4; k++)
    begin
      w = 0;
      while (mact !== 1'b1 && w < 100) @(posedge clk_i) #1 w++;
      @(posedge clk_i);
      istart <= 1'b1; ilen <= k[1:0];
      @(posedge clk_i);
      istart <= 1'b0;
      t = 0;
      w = 0;
      do @(posedge clk_i) #1 begin t += mact; w++; end while (idone !== 1'b1 && w < 300);
      chk(t, (k == 0) ? 2 : (k == 1) ? 4 : 5);
    end
    @(posedge clk_i);
    irqp <= 1'b1; rfi <= 1'b1;
    @(posedge clk_i);
    rfi <= 1'b0;
    #1 chk({nmi, itk, flg}, 12'h004);
    // long pin reset in stop mode with long delay and rc options
    @(posedge clk_i);
    irqp <= 1'b0; stop <= 1'b1; dopt <= 1'b1; otyp <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk(oen, 0);
    pulse_pin(8'd40);
    repeat (10) @(posedge clk_i);
    #1 chk({crst, iopu, oen, rsts[0]}, 4'hf);
    while (pin_n !== 1'b1) @(posedge clk_i) #1;
    wait_run(n);
    chk(n >= NL + 3 && n <= NL + 12, 1);
    chk({lowp, nmi, orc, loads[3:0]}, 7'h32);
    rreg(8'hde, v);
    chk({v[6], v[0]}, 2'h3);
    @(posedge clk_i);
    stop <= 1'b0;
    dopt <= 1'b0;
    // brief glitch on the pin still gives a full start-up
    pulse_pin(8'd2);
    wait_run(n);
    chk(n >= NS + 3 && n <= NS + 16, 1);
    @(posedge clk_i);
    wdg <= 1'b1;
    @(posedge clk_i);
    wdg <= 1'b0;
    wait_run(n);
    chk(n >= NS + 1 && n <= NS + 12, 1);
    rreg(8'hde, v);
    chk({v[2], loads[3:0]}, 5'h14);
    @(posedge clk_i);
    por <= 1'b1;
    repeat (6) @(posedge clk_i);
    por <= 1'b0;
    wait_run(n);
    rreg(8'hde, v);
    chk({v[1], loads[3:0]}, 5'h15);
    end_of_test;
  end
endmodule // tb
`default_nettype wire
